// File: ccib_bank.sv
// Identification, interrupt aggregation and buffer control register bank
//
// Summary of operation
// - A read-only 32-bit word reports chip and unit versions.
// - Version fields sit at the chip, unit and bus controller positions.
// - All unit interrupts merge onto one active-low host interrupt.
// - Host interrupt stays low until every pending unmasked unit interrupt is serviced or masked.
// - All units have equal priority; no ordering among them.
// - Mask bit 1 blocks a unit's interrupt; 0 lets it pass.
// - Mask bits: DES 27, stream 28, digest 29, random 30, public key 31.
// - One status read shows all units' interrupt state.
// - Input count mask sets words per input block into the unit.
// - Input start address is the offset receiving the first word.
// - Output count mask sets words per output block from the unit.
// - Output start address is the offset of the first output word.
// - A four-bit destination picks at most one active unit (codes 8 to C); host changes it between operations.
// - Auto-unmask clears the active unit's mask once it finishes its data.
`timescale 1ns/1ps
`default_nettype none

module ccib_bank #(
	// Version codes; values are arbitrary
	parameter logic [2:0] VER_CHIP = 3'h1,
	parameter logic [2:0] VER_DIGEST = 3'h1,
	parameter logic [2:0] VER_DES = 3'h1,
	parameter logic [2:0] VER_STREAM = 3'h1,
	parameter logic [2:0] VER_RANDOM = 3'h1,
	parameter logic [2:0] VER_BUSCTL = 3'h1,
	parameter logic [2:0] VER_PUBKEY = 3'h1
) (
	input wire logic mclk, // Master clock, 40 MHz
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [13:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic [4:0] unit_irq, // Unit interrupt levels, by unit index
	input wire logic unit_done, // Pulse: active unit finished its data
	output logic irq_n, // Host interrupt, active low
	output logic [7:0] in_count_mask, // Words per input block
	output logic [11:0] in_start_addr, // First input word offset
	output logic [7:0] out_count_mask, // Words per output block
	output logic [11:0] out_start_addr, // First output word offset
	output logic [3:0] active_dest, // Destination code
	output logic [4:0] unit_enable // One-hot active unit
);

	// =========================================================================
	// State
	ccib_pkg::ccib_bank_t s_q;
	ccib_pkg::ccib_bank_t s_d;

	// =========================================================================
	// Bus decode
	logic req;
	logic wr;
	logic rd;
	logic [11:0] idx;
	logic [31:0] lane_mask;

	assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
	assign wr = req & wb_we_i;
	assign rd = req & ~wb_we_i;
	assign idx = wb_adr_i[ccib_pkg::IDX_LSB +: ccib_pkg::IDX_W];

	always_comb begin
		for (int i = 0; i < ccib_pkg::SEL_W; i++) begin
			lane_mask[i*8 +: 8] = {8{wb_sel_i[i]}};
		end
	end

	// =========================================================================
	// Interrupt cells, one per unit
	logic [4:0] pend_vec;
	logic [4:0] mask_vec;
	logic [4:0] live_vec;
	logic [4:0] auto_clr;
	logic stat_rd;
	logic mask_wr;
	logic auto_fire;
	logic [31:0] mask_new;
	logic [31:0] mask_word;
	logic [31:0] pend_word;

	// Unit bits sit at the bottom of the mask and status words; the rest reads 0
	always_comb begin
		mask_word = 32'h00000000;
		mask_word[ccib_pkg::UNIT_LSB +: ccib_pkg::N_UNITS] = mask_vec;
		pend_word = 32'h00000000;
		pend_word[ccib_pkg::UNIT_LSB +: ccib_pkg::N_UNITS] = pend_vec;
	end

	assign stat_rd = rd & (idx == ccib_pkg::IDX_UNIT_IRQ_STATUS);
	assign mask_wr = wr & (idx == ccib_pkg::IDX_UNIT_IRQ_MASK);
	assign mask_new = (mask_word & ~lane_mask) | (wb_dat_i & lane_mask);
	assign auto_fire = unit_done & (s_q.auto_um == ccib_pkg::AUTO_ON) & (|s_q.unit_en);
	assign auto_clr = auto_fire ? s_q.unit_en : 5'h00;

	genvar g;
	generate
		for (g = 0; g < ccib_pkg::N_UNITS; g++) begin : g_cell
			ccib_irq_cell u_cell (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.unit_req(unit_irq[g]),
				.rd_clr(stat_rd),
				.mask_we(mask_wr & wb_sel_i[0]),
				.mask_wval(mask_new[ccib_pkg::UNIT_LSB + g]),
				.auto_clr(auto_clr[g]),
				.pend(pend_vec[g]),
				.mask(mask_vec[g]),
				.live(live_vec[g])
			);
		end
	endgenerate

	// =========================================================================
	// Destination decode
	function automatic logic [4:0] dest_onehot(input logic [3:0] code);
		logic [4:0] oh;
		oh = 5'h00;
		case (code)
			ccib_pkg::DEST_DES: oh[ccib_pkg::UNIT_DES] = 1'b1;
			ccib_pkg::DEST_STREAM: oh[ccib_pkg::UNIT_STREAM] = 1'b1;
			ccib_pkg::DEST_DIGEST: oh[ccib_pkg::UNIT_DIGEST] = 1'b1;
			ccib_pkg::DEST_RANDOM: oh[ccib_pkg::UNIT_RANDOM] = 1'b1;
			ccib_pkg::DEST_PUBKEY: oh[ccib_pkg::UNIT_PUBKEY] = 1'b1;
			default: oh = 5'h00;
		endcase
		return oh;
	endfunction

	// =========================================================================
	// Register images
	logic [31:0] id_word;
	logic [31:0] input_buffer_transfer_control_word;
	logic [31:0] output_buffer_transfer_control_word;
	logic [31:0] cst_word;
	logic [31:0] rd_word;
	logic [31:0] ib_new;
	logic [31:0] ob_new;
	logic [31:0] cst_new;

	always_comb begin
		id_word = 32'h00000000;
		id_word[ccib_pkg::VER_CHIP_LSB +: ccib_pkg::VER_W] = VER_CHIP;
		id_word[ccib_pkg::VER_DIGEST_LSB +: ccib_pkg::VER_W] = VER_DIGEST;
		id_word[ccib_pkg::VER_DES_LSB +: ccib_pkg::VER_W] = VER_DES;
		id_word[ccib_pkg::VER_STREAM_LSB +: ccib_pkg::VER_W] = VER_STREAM;
		id_word[ccib_pkg::VER_RANDOM_LSB +: ccib_pkg::VER_W] = VER_RANDOM;
		id_word[ccib_pkg::VER_BUSCTL_LSB +: ccib_pkg::VER_W] = VER_BUSCTL;
		id_word[ccib_pkg::VER_PUBKEY_LSB +: ccib_pkg::VER_W] = VER_PUBKEY;

		input_buffer_transfer_control_word = 32'h00000000;
		input_buffer_transfer_control_word[ccib_pkg::CNT_LSB +: ccib_pkg::CNT_W] = s_q.in_cnt;
		input_buffer_transfer_control_word[ccib_pkg::START_LSB +: ccib_pkg::START_W] = s_q.in_start;

		output_buffer_transfer_control_word = 32'h00000000;
		output_buffer_transfer_control_word[ccib_pkg::CNT_LSB +: ccib_pkg::CNT_W] = s_q.out_cnt;
		output_buffer_transfer_control_word[ccib_pkg::START_LSB +: ccib_pkg::START_W] = s_q.out_start;

		// All units in one word; reading it does not clear the flags
		cst_word = 32'h00000000;
		cst_word[ccib_pkg::CST_UNIT_LSB +: ccib_pkg::N_UNITS] = pend_vec;
		cst_word[ccib_pkg::IRQ_PEND_BIT] = ~s_q.irq_n;
		cst_word[ccib_pkg::DEST_LSB +: ccib_pkg::DEST_W] = s_q.dest;
		cst_word[ccib_pkg::AUTO_LSB +: ccib_pkg::AUTO_W] = s_q.auto_um;

		ib_new = (input_buffer_transfer_control_word & ~lane_mask) | (wb_dat_i & lane_mask);
		ob_new = (output_buffer_transfer_control_word & ~lane_mask) | (wb_dat_i & lane_mask);
		cst_new = (cst_word & ~lane_mask) | (wb_dat_i & lane_mask);

		case (idx)
			ccib_pkg::IDX_VERSION_ID: rd_word = id_word;
			ccib_pkg::IDX_UNIT_IRQ_MASK: rd_word = mask_word;
			ccib_pkg::IDX_IN_BUF_CTL: rd_word = input_buffer_transfer_control_word;
			ccib_pkg::IDX_OUT_BUF_CTL: rd_word = output_buffer_transfer_control_word;
			ccib_pkg::IDX_CTRL_STATUS: rd_word = cst_word;
			ccib_pkg::IDX_UNIT_IRQ_STATUS: rd_word = pend_word;
			default: rd_word = 32'h00000000;
		endcase
	end

	// =========================================================================
	// Next state
	always_comb begin
		s_d = s_q;
		// One wait state: ack follows the taken request, then drops
		s_d.ack = req;
		if (rd) begin
			s_d.rdat = rd_word;
		end
		// No unit outranks another: a plain OR of the live flags
		s_d.irq_n = ~(|live_vec);
		if (wr) begin
			case (idx)
				ccib_pkg::IDX_IN_BUF_CTL: begin
					s_d.in_cnt = ib_new[ccib_pkg::CNT_LSB +: ccib_pkg::CNT_W];
					s_d.in_start = ib_new[ccib_pkg::START_LSB +: ccib_pkg::START_W];
				end
				ccib_pkg::IDX_OUT_BUF_CTL: begin
					s_d.out_cnt = ob_new[ccib_pkg::CNT_LSB +: ccib_pkg::CNT_W];
					s_d.out_start = ob_new[ccib_pkg::START_LSB +: ccib_pkg::START_W];
				end
				ccib_pkg::IDX_CTRL_STATUS: begin
					// Changing the destination mid-operation is the host's hazard
					s_d.dest = cst_new[ccib_pkg::DEST_LSB +: ccib_pkg::DEST_W];
					s_d.auto_um = cst_new[ccib_pkg::AUTO_LSB +: ccib_pkg::AUTO_W];
					s_d.unit_en = dest_onehot(s_d.dest);
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q.ack <= 1'b0;
			s_q.rdat <= 32'h00000000;
			s_q.irq_n <= 1'b1;
			s_q.in_cnt <= ccib_pkg::CNT_RST;
			s_q.in_start <= ccib_pkg::START_RST;
			s_q.out_cnt <= ccib_pkg::CNT_RST;
			s_q.out_start <= ccib_pkg::START_RST;
			s_q.dest <= ccib_pkg::DEST_RST;
			s_q.auto_um <= ccib_pkg::AUTO_RST;
			s_q.unit_en <= 5'h00;
		end else begin
			s_q <= s_d;
		end
	end

	// =========================================================================
	// Outputs
	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = s_q.rdat;
	assign irq_n = s_q.irq_n;
	assign in_count_mask = s_q.in_cnt;
	assign in_start_addr = s_q.in_start;
	assign out_count_mask = s_q.out_cnt;
	assign out_start_addr = s_q.out_start;
	assign active_dest = s_q.dest;
	assign unit_enable = s_q.unit_en;

	// =========================================================================
	// Checks
	a_ack_single: assert property (
		@(posedge mclk) disable iff (sys_rst) req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");

	a_id_value: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(rd && idx == ccib_pkg::IDX_VERSION_ID) |=> (wb_ack_o && wb_dat_o == id_word))
		else $error("version word read wrong");

	a_irq_follows: assert property (
		@(posedge mclk) disable iff (sys_rst) (|live_vec) |=> !irq_n)
		else $error("unmasked pending interrupt not signalled");

	a_irq_held: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(!irq_n && $past(|live_vec) && (|live_vec)) |=> !irq_n)
		else $error("interrupt released while still pending");

	a_irq_quiet: assert property (
		@(posedge mclk) disable iff (sys_rst) ((pend_vec & ~mask_vec) == 5'h00) |=> irq_n)
		else $error("interrupt with nothing unmasked pending");

	a_mask_write: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(mask_wr && wb_sel_i[0]) |=> (mask_vec == $past(wb_dat_i[4:0])))
		else $error("mask write not stored");

	a_stat_read: assert property (
		@(posedge mclk) disable iff (sys_rst)
		stat_rd |=> (wb_dat_o == {27'h0, $past(pend_vec)}))
		else $error("status read wrong");

	a_in_ctl: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(wr && idx == ccib_pkg::IDX_IN_BUF_CTL && wb_sel_i == 4'hF)
		|=> (in_count_mask == $past(wb_dat_i[23:16]) && in_start_addr == $past(wb_dat_i[11:0])))
		else $error("input buffer control not stored");

	a_out_ctl: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(wr && idx == ccib_pkg::IDX_OUT_BUF_CTL && wb_sel_i == 4'hF)
		|=> (out_count_mask == $past(wb_dat_i[23:16]) && out_start_addr == $past(wb_dat_i[11:0])))
		else $error("output buffer control not stored");

	a_one_unit: assert property (
		@(posedge mclk) disable iff (sys_rst)
		$onehot0(unit_enable) && ((|unit_enable) == (active_dest >= ccib_pkg::DEST_DES
		&& active_dest <= ccib_pkg::DEST_PUBKEY)))
		else $error("more than one active unit");

	a_auto_unmask: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(auto_fire && !mask_wr) |=> ((mask_vec & $past(unit_enable)) == 5'h00))
		else $error("auto-unmask did not clear mask");

	a_ack_answer: assert property (
		@(posedge mclk) disable iff (sys_rst) wb_ack_o |-> $past(req))
		else $error("ack without a taken request");

	// Hold checks: read data, buffer control and destination move only on bus accesses; then status clear, auto-off and unmapped-read checks
	a_rdat_hold: assert property (
		@(posedge mclk) disable iff (sys_rst) !rd |=> $stable(wb_dat_o))
		else $error("read data changed without a read");

	a_ctl_hold: assert property (
		@(posedge mclk) disable iff (sys_rst)
		!wr |=> $stable({in_count_mask, in_start_addr, out_count_mask, out_start_addr}))
		else $error("buffer control changed without a write");

	a_dest_hold: assert property (
		@(posedge mclk) disable iff (sys_rst)
		!(wr && idx == ccib_pkg::IDX_CTRL_STATUS) |=> $stable({active_dest, unit_enable}))
		else $error("destination changed without a write");

	a_irq_release: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(stat_rd && unit_irq == 5'h00) |=> (pend_vec == 5'h00))
		else $error("status read left a flag set");

	a_auto_off: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(unit_done && s_q.auto_um != ccib_pkg::AUTO_ON && !mask_wr) |=> $stable(mask_vec))
		else $error("mask cleared with auto-unmask off");

	a_unmapped_zero: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(rd && (idx < ccib_pkg::IDX_VERSION_ID || idx > ccib_pkg::IDX_UNIT_IRQ_STATUS))
		|=> (wb_dat_o == 32'h00000000))
		else $error("unmapped read not zero");

endmodule

`default_nettype wire

// File: ccib_pkg.sv
// Constants and state types for the identification, interrupt and buffer control register bank
package ccib_pkg;

	// =========================================================================
	// Bus geometry
	// Register byte address = word index * 4; index is the byte address [13:2]
	localparam int ADR_W = 14;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 12;
	localparam int DATA_W = 32;
	localparam int SEL_W = 4;

	// =========================================================================
	// Register word indices
	localparam logic [11:0] IDX_VERSION_ID = 12'h901;
	localparam logic [11:0] IDX_UNIT_IRQ_MASK = 12'h902;
	localparam logic [11:0] IDX_IN_BUF_CTL = 12'h903;
	localparam logic [11:0] IDX_OUT_BUF_CTL = 12'h904;
	localparam logic [11:0] IDX_CTRL_STATUS = 12'h905;
	localparam logic [11:0] IDX_UNIT_IRQ_STATUS = 12'h906;

	// =========================================================================
	// Field positions, little-endian numbering (big-endian bit n sits at 31-n)
	localparam int VER_W = 3;
	localparam int VER_CHIP_LSB = 21;
	localparam int VER_DIGEST_LSB = 18;
	localparam int VER_DES_LSB = 15;
	localparam int VER_STREAM_LSB = 12;
	localparam int VER_RANDOM_LSB = 9;
	localparam int VER_BUSCTL_LSB = 3;
	localparam int VER_PUBKEY_LSB = 0;

	// Unit index equals its bit in the mask and interrupt status words
	localparam int N_UNITS = 5;
	localparam int UNIT_PUBKEY = 0;
	localparam int UNIT_RANDOM = 1;
	localparam int UNIT_DIGEST = 2;
	localparam int UNIT_STREAM = 3;
	localparam int UNIT_DES = 4;
	localparam int UNIT_LSB = 0;

	localparam int CNT_LSB = 16;
	localparam int CNT_W = 8;
	localparam int START_LSB = 0;
	localparam int START_W = 12;

	localparam int AUTO_LSB = 1;
	localparam int AUTO_W = 3;
	localparam int DEST_LSB = 4;
	localparam int DEST_W = 4;
	localparam int IRQ_PEND_BIT = 8;
	localparam int CST_UNIT_LSB = 9;

	// =========================================================================
	// Encodings
	localparam logic [3:0] DEST_DES = 4'h8;
	localparam logic [3:0] DEST_STREAM = 4'h9;
	localparam logic [3:0] DEST_DIGEST = 4'hA;
	localparam logic [3:0] DEST_RANDOM = 4'hB;
	localparam logic [3:0] DEST_PUBKEY = 4'hC;
	localparam logic [2:0] AUTO_ON = 3'h1;

	// =========================================================================
	// Reset values
	localparam logic UNIT_MASK_RST = 1'b1;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [11:0] START_RST = 12'h000;
	localparam logic [3:0] DEST_RST = 4'h0;
	localparam logic [2:0] AUTO_RST = 3'h0;

	// =========================================================================
	// State of one interrupt cell
	typedef struct packed {
		logic pend;
		logic mask;
	} ccib_cell_t;

	// State of the register bank
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic irq_n;
		logic [7:0] in_cnt;
		logic [11:0] in_start;
		logic [7:0] out_cnt;
		logic [11:0] out_start;
		logic [3:0] dest;
		logic [2:0] auto_um;
		logic [4:0] unit_en;
	} ccib_bank_t;

endpackage

// File: ccib_irq_cell.sv
// One execution unit's sticky interrupt flag and mask bit
`timescale 1ns/1ps
`default_nettype none

module ccib_irq_cell (
	input wire logic mclk, // Master clock
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic unit_req, // Interrupt level from the unit
	input wire logic rd_clr, // Status register read taken
	input wire logic mask_we, // Host writes this mask bit
	input wire logic mask_wval, // Value written to the mask bit
	input wire logic auto_clr, // Auto-unmask of this unit
	output logic pend, // Sticky pending flag
	output logic mask, // Mask bit, 1 blocks
	output logic live // Pending and not masked
);

	// =========================================================================
	// State
	ccib_pkg::ccib_cell_t s_q;
	ccib_pkg::ccib_cell_t s_d;

	always_comb begin
		s_d = s_q;
		// A request in the clearing cycle keeps the flag set
		s_d.pend = unit_req | (s_q.pend & ~rd_clr);
		// Host write wins over auto-unmask so software keeps the last word
		if (mask_we) begin
			s_d.mask = mask_wval;
		end else if (auto_clr) begin
			s_d.mask = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q.pend <= 1'b0;
			s_q.mask <= ccib_pkg::UNIT_MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign pend = s_q.pend;
	assign mask = s_q.mask;
	assign live = s_q.pend & ~s_q.mask;

	// =========================================================================
	// Checks
	a_pend_set_wins: assert property (
		@(posedge mclk) disable iff (sys_rst) unit_req |=> pend)
		else $error("request lost while flag cleared");

	a_mask_blocks: assert property (
		@(posedge mclk) disable iff (sys_rst)
		(mask && !mask_we && !auto_clr) |=> (mask && !live))
		else $error("masked unit reaches interrupt");

endmodule

`default_nettype wire

// File: ccib_host_model.sv
// Host processor model: a classic Wishbone master with bounded waits
`timescale 1ns/1ps
`default_nettype none

module ccib_host_model (
	input wire logic mclk, // Master clock
	input wire logic wb_ack_o, // Acknowledge from the bank
	input wire logic [31:0] wb_dat_o, // Read data from the bank
	output logic wb_cyc_i, // Cycle
	output logic wb_stb_i, // Strobe
	output logic wb_we_i, // Write enable
	output logic [13:0] wb_adr_i, // Byte address
	output logic [3:0] wb_sel_i, // Byte lanes
	output logic [31:0] wb_dat_i // Write data
);
	// =========================================================
	// Idle bus
	initial begin
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 14'h0000;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
	end

	// =========================================================
	// One access
	// No byte swap on this bus, so the version word is always read big-endian
	// Request is held until ack is sampled high or 16 cycles pass; ok stays low if no answer came
	task automatic access(input logic we, input logic [11:0] idx, input logic [3:0] sel,
		input logic [31:0] wdat, output logic [31:0] rdat, output logic ok);
		int n;
		ok = 1'b0;
		rdat = 32'h0000_0000;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= sel;
		wb_dat_i <= wdat;
		for (n = 0; n < 16; n++) begin
			@(posedge mclk);
			if (wb_ack_o === 1'b1) begin
				ok = 1'b1;
				rdat = wb_dat_o;
				break;
			end
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_dat_i <= ~wdat;
	endtask
endmodule

`default_nettype wire

// File: tb.sv
// Self-checking testbench for the identification, interrupt and buffer control bank
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [13:0] wb_adr_i;
	logic [3:0] wb_sel_i, active_dest;
	logic [31:0] wb_dat_i, wb_dat_o, r;
	logic [4:0] unit_irq = 5'h00;
	logic [4:0] unit_enable;
	logic unit_done = 1'b0;
	logic irq_n;
	logic [7:0] in_count_mask, out_count_mask;
	logic [11:0] in_start_addr, out_start_addr;
	int n_mismatch = 0;
	int n_compared = 0;
	// Distinct codes so a swapped field shows up; chip and public key keep the default 1
	localparam logic [31:0] VER_EXP = {8'h00, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h6, 3'h1};
	localparam logic [11:0] I_VER = ccib_pkg::IDX_VERSION_ID;
	localparam logic [11:0] I_MSK = ccib_pkg::IDX_UNIT_IRQ_MASK;
	localparam logic [11:0] I_CST = ccib_pkg::IDX_CTRL_STATUS;
	localparam logic [11:0] I_IST = ccib_pkg::IDX_UNIT_IRQ_STATUS;

	always #12.5 mclk = ~mclk;

	ccib_bank #(.VER_DIGEST(3'h2), .VER_DES(3'h3), .VER_STREAM(3'h4), .VER_RANDOM(3'h5),
		.VER_BUSCTL(3'h6)) dut (.mclk(mclk),
		.sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .unit_irq(unit_irq), .unit_done(unit_done), .irq_n(irq_n),
		.in_count_mask(in_count_mask), .in_start_addr(in_start_addr),
		.out_count_mask(out_count_mask), .out_start_addr(out_start_addr),
		.active_dest(active_dest), .unit_enable(unit_enable));

	ccib_host_model host (.mclk(mclk), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));

	// =========================================================
	// Helpers
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic we, input logic [11:0] idx, input logic [3:0] sel,
		input logic [31:0] d, output logic [31:0] q);
		logic ok;
		host.access(we, idx, sel, d, q, ok);
		if (ok !== 1'b1) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, idx, 4'hF, d, q);
	endtask

	task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		acc(1'b0, idx, 4'hF, 32'h0000_0000, q);
		chk(q, exp);
	endtask

	// Waits a bounded time for the host line to reach a level
	task automatic wirq(input logic lvl);
		int n;
		for (n = 0; n < 8 && irq_n !== lvl; n++) begin
			@(posedge mclk);
		end
		chk({31'h0, irq_n}, {31'h0, lvl});
	endtask

	task automatic pulse_irq(input logic [4:0] m);
		@(posedge mclk);
		unit_irq <= m;
		@(posedge mclk);
		unit_irq <= 5'h00;
	endtask

	task automatic pulse_done();
		@(posedge mclk);
		unit_done <= 1'b1;
		@(posedge mclk);
		unit_done <= 1'b0;
	endtask

	// =========================================================
	// Main sequence
	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		chk({31'h0, irq_n}, 32'h1);
		chk({in_count_mask, out_count_mask, active_dest, 7'h0, unit_enable}, 32'h0);
		rchk(I_MSK, 32'h0000_001F);
		rchk(I_VER, VER_EXP);
		wr(I_VER, 32'h0000_0000);
		rchk(I_VER, VER_EXP);
		wr(I_MSK, 32'hFFFF_FFEA);
		rchk(I_MSK, 32'h0000_000A);
		wr(ccib_pkg::IDX_IN_BUF_CTL, 32'hA5A5_5ABC);
		chk({in_count_mask, 12'h0, in_start_addr}, 32'hA500_0ABC);
		acc(1'b1, ccib_pkg::IDX_IN_BUF_CTL, 4'h4, 32'hFFFF_FFFF, r);
		rchk(ccib_pkg::IDX_IN_BUF_CTL, 32'h00FF_0ABC);
		wr(ccib_pkg::IDX_OUT_BUF_CTL, 32'h123C_4DEF);
		chk({out_count_mask, 12'h0, out_start_addr}, 32'h3C00_0DEF);
		rchk(ccib_pkg::IDX_OUT_BUF_CTL, 32'h003C_0DEF);
		wr(12'h907, 32'hFFFF_FFFF);
		rchk(12'h907, 32'h0000_0000);
		for (int c = 7; c <= 13; c++) begin
			wr(I_CST, 32'(c) << 4);
			chk({28'h0, active_dest}, 32'(c));
			chk({27'h0, unit_enable}, (c >= 8 && c <= 12) ? (32'h1 << (12 - c)) : 32'h0);
		end
		// Masked request is held pending and reaches the host only once unmasked
		wr(I_MSK, 32'h0000_001F);
		pulse_irq(5'h10);
		repeat (4) @(posedge mclk);
		chk({31'h0, irq_n}, 32'h1);
		acc(1'b0, I_CST, 4'hF, 32'h0, r);
		chk(r & ~32'h0000_0100, 32'h0000_20D0);
		wr(I_MSK, 32'h0000_000F);
		wirq(1'b0);
		rchk(I_IST, 32'h0000_0010);
		wirq(1'b1);
		// All units at once, request held across the clearing read
		wr(I_MSK, 32'h0000_0000);
		@(posedge mclk);
		unit_irq <= 5'h1F;
		wirq(1'b0);
		rchk(I_IST, 32'h0000_001F);
		repeat (4) @(posedge mclk);
		chk({31'h0, irq_n}, 32'h0);
		unit_irq <= 5'h00;
		rchk(I_IST, 32'h0000_001F);
		wirq(1'b1);
		// Auto-unmask is off first, then on for the DES destination
		wr(I_MSK, 32'h0000_001F);
		wr(I_CST, 32'h0000_0080);
		pulse_done();
		rchk(I_MSK, 32'h0000_001F);
		wr(I_CST, 32'h0000_0082);
		acc(1'b0, I_CST, 4'hF, 32'h0, r);
		chk(r & ~32'h0000_0100, 32'h0000_0082);
		pulse_done();
		rchk(I_MSK, 32'h0000_000F);
		pulse_irq(5'h10);
		wirq(1'b0);
		rchk(I_IST, 32'h0000_0010);
		wirq(1'b1);
		report_and_stop();
	end
endmodule

`default_nettype wire
